// >>> logic/ppm_pin_mux.sv
// Notes on behaviour
// R1: host mode puts host data on port A
// R2: host mode: strobes in, drive-disable out
// R3: host mode: chan B clocks/rx become addresses
// R4: host mode: chan B sync becomes chip select
// R5: two bits pick cpu, chan B, host
// R6: port C takes chan A pins, memwrite pin only with PM_MEMRQ set
// R7: daisy pin input or output by bit
// R8: memory read pin gives read or request
// R9: port C bits 7,6 read irq pins
// R10: port B1 mode holds chan0 cts low
// R11: unselected inputs idle; only selected drives
// R12: select change acts cycle after write
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ppm_pin_mux #(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [ppm_pkg::PPM_DW-1:0] pwdata,
	output logic [ppm_pkg::PPM_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire ppm_pkg::ppm_pad_in_type pad_in,
	output ppm_pkg::ppm_pad_out_type pad_out,
	input wire ppm_pkg::ppm_unit_out_type unit_out,
	output ppm_pkg::ppm_unit_in_type unit_in
);
	import ppm_pkg::*;

	logic [PPM_RW-1:0] sys_r;
	logic [PPM_RW-1:0] pin_r;
	logic ready_r;
	logic slverr_r;
	logic [PPM_DW-1:0] rdata_r;
	ppm_pad_out_type pad_r;
	ppm_pad_out_type pad_nxt;
	ppm_unit_in_type uin_r;
	ppm_unit_in_type uin_nxt;
	ppm_pad_in_type pad_s;
	ppm_fn_type fn;
	logic host, acc, done, mapped;
	logic [PPM_RW-1:0] rd_mux;
	logic [7:0] pa_o_nxt, pa_oe_nxt, gpa_nxt, hd_nxt;

	if (ADDR_W < PPM_OFS_W) begin : g_chk
		$error("ppm_pin_mux: address too narrow for the register map");
	end

	// ----------------------------------------------------------------
	// pad inputs cross into pclk
	// ----------------------------------------------------------------
	ppm_sync2 #(.W($bits(ppm_pad_in_type))) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(pad_in),
		.q(pad_s)
	);

	// ----------------------------------------------------------------
	// apb slave, one wait state, error on unmapped offsets
	// ----------------------------------------------------------------
	assign acc = psel & penable;
	assign done = acc & ready_r;
	assign mapped = ((paddr >> PPM_OFS_W) == '0) &&
		(paddr[PPM_OFS_W-1:0] == PPM_OFS_SYS || paddr[PPM_OFS_W-1:0] == PPM_OFS_PIN ||
		paddr[PPM_OFS_W-1:0] == PPM_OFS_PORTC);

	always_comb begin
		rd_mux = '0;
		case (paddr[PPM_OFS_W-1:0])
			PPM_OFS_SYS: rd_mux = sys_r;
			PPM_OFS_PIN: rd_mux = pin_r;
			PPM_OFS_PORTC: rd_mux = uin_r.pc_i;
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_r <= 1'b0;
			slverr_r <= 1'b0;
			rdata_r <= '0;
		end else begin
			ready_r <= acc & ~ready_r;
			if (acc & ~ready_r) begin
				slverr_r <= ~mapped;
				rdata_r <= (mapped & ~pwrite) ? {{(PPM_DW-PPM_RW){1'b0}}, rd_mux} : '0;
			end
		end
	end

	// selects change only on the completing edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_r <= PPM_SYS_RST;
			pin_r <= PPM_PIN_RST;
		end else if (done && pwrite && mapped) begin
			if (paddr[PPM_OFS_W-1:0] == PPM_OFS_SYS) begin
				sys_r <= pwdata[PPM_RW-1:0]; // R12
			end
			if (paddr[PPM_OFS_W-1:0] == PPM_OFS_PIN) begin
				pin_r <= pwdata[PPM_RW-1:0]; // R12
			end
		end
	end

	assign prdata = rdata_r;
	assign pready = ready_r;
	assign pslverr = slverr_r;

	// ----------------------------------------------------------------
	// port A: general purpose or host data
	// ----------------------------------------------------------------
	assign host = sys_r[SC_HOST];

	for (genvar gi = 0; gi < 8; gi++) begin : g_pa
		assign pa_o_nxt[gi] = host ? unit_out.host_data_o[gi] : unit_out.gpio_pa_o[gi]; // R1
		assign pa_oe_nxt[gi] = host ? unit_out.host_data_oe : unit_out.gpio_pa_oe[gi]; // R11
		assign gpa_nxt[gi] = host ? 1'b0 : pad_s.pa[gi]; // R11
		assign hd_nxt[gi] = host ? pad_s.pa[gi] : 1'b0; // R1
	end

	// ----------------------------------------------------------------
	// routing of every other shared pin
	// ----------------------------------------------------------------
	always_comb begin
		pad_nxt = '0;
		uin_nxt = PPM_UIN_IDLE; // R11
		pad_nxt.pa_o = pa_o_nxt;
		pad_nxt.pa_oe = pa_oe_nxt;
		uin_nxt.gpio_pa_i = gpa_nxt;
		uin_nxt.host_data_i = hd_nxt;
		if (host) begin
			uin_nxt.host_read_strobe_n = pad_s.b_cd; // R2
			uin_nxt.host_write_strobe_n = pad_s.b_cs; // R2
			pad_nxt.b_tx = '{unit_out.host_bus_drive_disable_n, 1'b1}; // R2
			uin_nxt.host_reg_addr = {pad_s.b_rck, pad_s.b_rx, pad_s.b_tck}; // R3
			uin_nxt.host_select_n = pad_s.b_sy; // R4
		end else begin
			uin_nxt.chan_b_carrier_detect_n = pad_s.b_cd;
			uin_nxt.chan_b_clear_to_send_n = pad_s.b_cs;
			pad_nxt.b_tx = '{unit_out.chan_b_tx_line, 1'b1};
			pad_nxt.b_tck = unit_out.chan_b_txrx_clock_n;
			uin_nxt.chan_b_txrx_clock_n = pad_s.b_tck;
			uin_nxt.chan_b_rx_line = pad_s.b_rx;
			uin_nxt.chan_b_rxtx_clock_n = pad_s.b_rck;
			pad_nxt.b_sy = unit_out.chan_b_sync_n;
			uin_nxt.chan_b_sync_n = pad_s.b_sy;
		end
		case (fn)
			PPM_FN_CPU: begin
				pad_nxt.tri_a = unit_out.async1_clock_or_dma0_end;
				uin_nxt.async1_clock_or_dma0_end = pad_s.tri_a;
				uin_nxt.dma1_request_n = pad_s.tri_b;
				pad_nxt.tri_c = '{unit_out.dma1_transfer_end_n, 1'b1};
			end
			PPM_FN_CHB: begin
				pad_nxt.tri_a = '{unit_out.chan_b_terminal_ready_or_request, 1'b1}; // R5
				pad_nxt.tri_b = '{unit_out.chan_b_wait_or_request, 1'b1}; // R5
				pad_nxt.tri_c = '{unit_out.chan_b_request_to_send_n, 1'b1}; // R5
			end
			PPM_FN_HOST: begin
				pad_nxt.tri_a = '{unit_out.host_interrupt_out, 1'b1}; // R5
				pad_nxt.tri_b = '{unit_out.host_tx_ready_n, 1'b1}; // R5
				pad_nxt.tri_c = '{unit_out.host_rx_ready_n, 1'b1}; // R5
			end
			default: begin
				pad_nxt.tri_c = '{1'b1, 1'b0};
			end
		endcase
		if (sys_r[SC_PC]) begin
			pad_nxt.a_wr = '{unit_out.pc_o[5], unit_out.pc_oe[5]}; // R6
			pad_nxt.a_dtr = '{unit_out.pc_o[3], unit_out.pc_oe[3]}; // R6
			pad_nxt.a_cts = '{unit_out.pc_o[1], unit_out.pc_oe[1]}; // R6
			pad_nxt.a_cd = '{unit_out.pc_o[0], unit_out.pc_oe[0]}; // R6
			pad_nxt.a_sy = '{unit_out.pc_o[4], unit_out.pc_oe[4]}; // R6
			uin_nxt.pc_i[5] = pad_s.a_wr;
			uin_nxt.pc_i[4] = pad_s.a_sy;
			uin_nxt.pc_i[3] = pad_s.a_dtr;
			uin_nxt.pc_i[1] = pad_s.a_cts;
			uin_nxt.pc_i[0] = pad_s.a_cd;
		end else begin
			pad_nxt.a_wr = '{unit_out.a_wait_req, 1'b1};
			pad_nxt.a_dtr = '{unit_out.a_dtr_req, 1'b1};
			uin_nxt.a_cts_n = pad_s.a_cts;
			uin_nxt.a_cd_n = pad_s.a_cd;
			uin_nxt.a_sync_n = pad_s.a_sy;
		end
		if (!pin_r[PM_MEMRQ]) begin
			pad_nxt.wr_pin = '{unit_out.memory_write_strobe_n, 1'b1};
		end else if (sys_r[SC_PC]) begin
			pad_nxt.wr_pin = '{unit_out.pc_o[2], unit_out.pc_oe[2]}; // R6
			uin_nxt.pc_i[2] = pad_s.wr_pin;
		end else begin
			pad_nxt.wr_pin = '{unit_out.chan_a_request_to_send, 1'b1}; // R6
		end
		pad_nxt.rd_pin = '{pin_r[PM_MEMRQ] ? unit_out.memory_request_n :
			unit_out.memory_read_strobe_n, 1'b1}; // R8
		if (pin_r[PM_DAISY]) begin
			pad_nxt.chain = '{unit_out.daisy_priority_out, 1'b1}; // R7
		end else begin
			uin_nxt.daisy_priority_in = pad_s.chain; // R7
		end
		uin_nxt.pc_i[7] = pad_s.irq2_n; // R9
		uin_nxt.pc_i[6] = pad_s.irq1_n; // R9
		if (sys_r[SC_PB]) begin
			pad_nxt.b1_pin = unit_out.portb_bit1;
			uin_nxt.portb_bit1 = pad_s.b1_pin;
			uin_nxt.chan0_cts_n = 1'b0; // R10
		end else begin
			uin_nxt.chan0_cts_n = pad_s.b1_pin;
		end
	end

	assign fn = sys_r[SC_HOST] ? PPM_FN_HOST : (sys_r[SC_CHB] ? PPM_FN_CHB : PPM_FN_CPU);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_r <= '0;
			uin_r <= PPM_UIN_IDLE;
		end else begin
			pad_r <= pad_nxt; // R12
			uin_r <= uin_nxt;
		end
	end

	assign pad_out = pad_r;
	assign unit_in = uin_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_r1;
		host |=> pad_r.pa_oe == {8{$past(unit_out.host_data_oe)}} &&
			uin_r.gpio_pa_i == 8'h00;
	endproperty
	a_r1: assert property (p_r1) else $error("port A not host data"); // R1
	property p_r2;
		host |=> pad_r.b_tx.o == $past(unit_out.host_bus_drive_disable_n) &&
			uin_r.host_read_strobe_n == $past(pad_s.b_cd) && uin_r.chan_b_carrier_detect_n;
	endproperty
	a_r2: assert property (p_r2) else $error("host strobe routing wrong"); // R2
	property p_r3;
		host |=> uin_r.host_reg_addr == $past({pad_s.b_rck, pad_s.b_rx, pad_s.b_tck});
	endproperty
	a_r3: assert property (p_r3) else $error("host address routing wrong"); // R3
	property p_r4;
		1'b1 |=> uin_r.host_select_n == ($past(host) ? $past(pad_s.b_sy) : 1'b1) &&
			!pad_r.b_tck.oe == ($past(host) || !$past(unit_out.chan_b_txrx_clock_n.oe));
	endproperty
	a_r4: assert property (p_r4) else $error("host select routing wrong"); // R4
	property p_r5;
		(!sys_r[SC_HOST] && sys_r[SC_CHB]) |=>
			pad_r.tri_c.o == $past(unit_out.chan_b_request_to_send_n) && uin_r.dma1_request_n;
	endproperty
	a_r5: assert property (p_r5) else $error("channel B function not routed"); // R5
	property p_r6;
		sys_r[SC_PC] |=> uin_r.a_cts_n && uin_r.pc_i[1] == $past(pad_s.a_cts);
	endproperty
	a_r6: assert property (p_r6) else $error("port C routing wrong"); // R6
	property p_r7;
		pin_r[PM_DAISY] ##1 pin_r[PM_DAISY] |-> pad_r.chain.oe && uin_r.daisy_priority_in;
	endproperty
	a_r7: assert property (p_r7) else $error("daisy pin direction wrong"); // R7
	property p_r8;
		pin_r[PM_MEMRQ] |=> pad_r.rd_pin.o == $past(unit_out.memory_request_n);
	endproperty
	a_r8: assert property (p_r8) else $error("memory read pin wrong"); // R8
	property p_r9;
		$rose(pad_s.irq2_n) |=> uin_r.pc_i[7];
	endproperty
	a_r9: assert property (p_r9) else $error("port C bit 7 not live"); // R9
	property p_r10;
		sys_r[SC_PB] |=> !uin_r.chan0_cts_n;
	endproperty
	a_r10: assert property (p_r10) else $error("channel 0 cts not held low"); // R10
	property p_r11;
		!host |=> pad_r.pa_oe == $past(unit_out.gpio_pa_oe) && uin_r.host_data_i == 8'h00;
	endproperty
	a_r11: assert property (p_r11) else $error("unselected unit drives port A"); // R11
	property p_r12;
		(done && pwrite && mapped && paddr[PPM_OFS_W-1:0] == PPM_OFS_SYS) |=>
			sys_r == $past(pwdata[PPM_RW-1:0]) ##1 pad_r.b_tx.o == ($past(sys_r[SC_HOST]) ?
			$past(unit_out.host_bus_drive_disable_n) : $past(unit_out.chan_b_tx_line));
	endproperty
	a_r12: assert property (p_r12) else $error("select write not applied"); // R12
endmodule : ppm_pin_mux
`default_nettype wire

// >>> logic/ppm_pkg.sv
`default_nettype none
package ppm_pkg;

	// ----------------------------------------------------------------
	// register map and field positions
	// ----------------------------------------------------------------
	localparam int PPM_DW = 32;
	localparam int PPM_RW = 8;
	localparam int PPM_OFS_W = 4;
	localparam logic [3:0] PPM_OFS_SYS = 4'h0;
	localparam logic [3:0] PPM_OFS_PIN = 4'h4;
	localparam logic [3:0] PPM_OFS_PORTC = 4'h8;
	localparam int SC_HOST = 1;
	localparam int SC_CHB = 2;
	localparam int SC_PB = 5;
	localparam int SC_PC = 7;
	localparam int PM_DAISY = 2;
	localparam int PM_MEMRQ = 3;
	localparam logic [7:0] PPM_SYS_RST = 8'h00;
	localparam logic [7:0] PPM_PIN_RST = 8'h00;

	// ----------------------------------------------------------------
	// function choice on the three-way pins
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PPM_FN_CPU = 2'b00,
		PPM_FN_CHB = 2'b01,
		PPM_FN_HOST = 2'b10
	} ppm_fn_type;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic o;
		logic oe;
	} ppm_drv_type;

	typedef struct packed {
		logic [7:0] pa;
		logic b_cd, b_cs, b_tck, b_rx, b_rck, b_sy;
		logic tri_a, tri_b;
		logic a_wr, a_dtr, a_cts, a_cd, a_sy, wr_pin, chain, b1_pin;
		logic irq1_n, irq2_n;
	} ppm_pad_in_type;

	typedef struct packed {
		logic [7:0] pa_o;
		logic [7:0] pa_oe;
		ppm_drv_type b_tx, b_tck, b_sy, tri_a, tri_b, tri_c;
		ppm_drv_type a_wr, a_dtr, a_cts, a_cd, a_sy, wr_pin, rd_pin, chain, b1_pin;
	} ppm_pad_out_type;

	typedef struct packed {
		logic [7:0] gpio_pa_o;
		logic [7:0] gpio_pa_oe;
		logic [7:0] host_data_o;
		logic host_data_oe;
		logic chan_b_tx_line;
		logic host_bus_drive_disable_n;
		ppm_drv_type chan_b_txrx_clock_n;
		ppm_drv_type chan_b_sync_n;
		ppm_drv_type async1_clock_or_dma0_end;
		logic chan_b_terminal_ready_or_request;
		logic host_interrupt_out;
		logic chan_b_wait_or_request;
		logic host_tx_ready_n;
		logic dma1_transfer_end_n;
		logic chan_b_request_to_send_n;
		logic host_rx_ready_n;
		logic a_wait_req;
		logic a_dtr_req;
		logic chan_a_request_to_send;
		logic memory_write_strobe_n;
		logic memory_read_strobe_n;
		logic memory_request_n;
		logic daisy_priority_out;
		logic [5:0] pc_o;
		logic [5:0] pc_oe;
		ppm_drv_type portb_bit1;
	} ppm_unit_out_type;

	typedef struct packed {
		logic [7:0] gpio_pa_i;
		logic [7:0] host_data_i;
		logic chan_b_carrier_detect_n;
		logic host_read_strobe_n;
		logic chan_b_clear_to_send_n;
		logic host_write_strobe_n;
		logic chan_b_txrx_clock_n;
		logic [2:0] host_reg_addr;
		logic chan_b_rx_line;
		logic chan_b_rxtx_clock_n;
		logic chan_b_sync_n;
		logic host_select_n;
		logic async1_clock_or_dma0_end;
		logic dma1_request_n;
		logic a_cts_n;
		logic a_cd_n;
		logic a_sync_n;
		logic daisy_priority_in;
		logic chan0_cts_n;
		logic portb_bit1;
		logic [7:0] pc_i;
	} ppm_unit_in_type;

	// inactive level of every unit input when its pin serves another unit
	localparam ppm_unit_in_type PPM_UIN_IDLE = '{8'h00, 8'h00, 1'b1, 1'b1, 1'b1, 1'b1,
		1'b1, 3'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
		1'b0, 8'h00};

endpackage : ppm_pkg
`default_nettype wire

// >>> logic/ppm_sync2.sv
`timescale 1ns/10ps
`default_nettype none
module ppm_sync2 #(
	parameter int W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// ----------------------------------------------------------------
	// two-stage synchroniser, first stage feeds only the second
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end

	if (W < 1) begin : g_chk
		$error("ppm_sync2: width must be at least one");
	end
endmodule : ppm_sync2
`default_nettype wire

// >>> tb/ppm_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module ppm_far_model (
	input wire ppm_pkg::ppm_pad_out_type pad_out,
	input wire ppm_pkg::ppm_pad_in_type far_lv,
	output var ppm_pkg::ppm_pad_in_type pad_in
);
	import ppm_pkg::*;

	// ----------------------------------------------------------------
	// pad resolution: the far side yields wherever the block drives
	// ----------------------------------------------------------------
	function automatic logic rs(input ppm_drv_type d, input logic f);
		return d.oe ? d.o : f;
	endfunction : rs

	always_comb begin
		pad_in = far_lv;
		for (int i = 0; i < 8; i++) begin
			pad_in.pa[i] = pad_out.pa_oe[i] ? pad_out.pa_o[i] : far_lv.pa[i];
		end
		pad_in.b_tck = rs(pad_out.b_tck, far_lv.b_tck);
		pad_in.b_sy = rs(pad_out.b_sy, far_lv.b_sy);
		pad_in.tri_a = rs(pad_out.tri_a, far_lv.tri_a);
		pad_in.tri_b = rs(pad_out.tri_b, far_lv.tri_b);
		pad_in.a_wr = rs(pad_out.a_wr, far_lv.a_wr);
		pad_in.a_dtr = rs(pad_out.a_dtr, far_lv.a_dtr);
		pad_in.a_cts = rs(pad_out.a_cts, far_lv.a_cts);
		pad_in.a_cd = rs(pad_out.a_cd, far_lv.a_cd);
		pad_in.a_sy = rs(pad_out.a_sy, far_lv.a_sy);
		pad_in.wr_pin = rs(pad_out.wr_pin, far_lv.wr_pin);
		pad_in.chain = rs(pad_out.chain, far_lv.chain);
		pad_in.b1_pin = rs(pad_out.b1_pin, far_lv.b1_pin);
	end
endmodule : ppm_far_model
`default_nettype wire

// >>> tb/tb_peripheral_pin_function_mux.sv
`timescale 1ns/10ps
`default_nettype none
module tb_peripheral_pin_function_mux;
	import ppm_pkg::*;

	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic er;
	ppm_pad_in_type pad_in, far_lv;
	ppm_pad_out_type pad_out;
	ppm_unit_out_type unit_out;
	ppm_unit_in_type unit_in;
	logic [127:0] rnd;
	int seed, err_count, check_count, sys_m, pin_m;
	int sys_tab[8] = '{'h00, 'h02, 'h04, 'h06, 'h20, 'h80, 'ha6, 'h84};

	ppm_pin_mux #(.ADDR_W(12)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
		.unit_out(unit_out), .unit_in(unit_in));
	ppm_far_model far (.pad_out(pad_out), .far_lv(far_lv), .pad_in(pad_in));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// ----------------------------------------------------------------
	// reporting and comparison
	// ----------------------------------------------------------------
	task automatic final_report;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : final_report

	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp

	task automatic chk_bus(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp(nm, e, g);
	endtask : chk_bus

	task automatic chk_pad(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp(nm, e, g);
	endtask : chk_pad

	// ----------------------------------------------------------------
	// apb master
	// ----------------------------------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_count++;
			final_report();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic settle;
		repeat (6) @(posedge pclk);
		@(negedge pclk);
	endtask : settle

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 12963;
		err_count = 0;
		check_count = 0;
		presetn = 1'b0;
		{psel, penable, pwrite} = 3'b000;
		paddr = 12'h000;
		pwdata = 32'h0;
		unit_out = '0;
		far_lv = '1;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		chk_bus("sys reset", 32'h0, rd);
		apb(1'b0, 12'h004, 32'h0);
		chk_bus("pin reset", 32'h0, rd);
		apb(1'b0, 12'h010, 32'h0);
		chk_bus("unmapped err", 32'h1, {31'h0, er});
		chk_bus("unmapped data", 32'h0, rd);
		apb(1'b1, 12'h008, 32'hff);
		chk_bus("ro write err", 32'h0, {31'h0, er});
		for (int i = 0; i < 8; i++) begin
			sys_m = sys_tab[i];
			pin_m = (i % 4) * 4;
			apb(1'b1, 12'h000, sys_m);
			apb(1'b1, 12'h004, pin_m);
			apb(1'b0, 12'h000, 32'h0);
			chk_bus("sys readback", sys_m, rd);
			rnd = {$random(seed), $random(seed), $random(seed), $random(seed)};
			@(posedge pclk);
			unit_out <= rnd[$bits(ppm_unit_out_type)-1:0];
			rnd = {$random(seed), $random(seed), $random(seed), $random(seed)};
			far_lv <= rnd[$bits(ppm_pad_in_type)-1:0];
			settle();
			if (sys_m[1]) begin
				chk_pad("pa_o", unit_out.host_data_o, pad_out.pa_o);
				chk_pad("pa_oe", {8{unit_out.host_data_oe}}, pad_out.pa_oe);
				chk_pad("host rd", far_lv.b_cd, unit_in.host_read_strobe_n);
				chk_pad("host wr", far_lv.b_cs, unit_in.host_write_strobe_n);
				chk_pad("chb cd idle", 1, unit_in.chan_b_carrier_detect_n);
				chk_pad("ddis", unit_out.host_bus_drive_disable_n, pad_out.b_tx.o);
				chk_pad("haddr", {far_lv.b_rck, far_lv.b_rx, far_lv.b_tck},
					unit_in.host_reg_addr);
				chk_pad("hcs", far_lv.b_sy, unit_in.host_select_n);
				chk_pad("tri_c", unit_out.host_rx_ready_n, pad_out.tri_c.o);
				chk_pad("tri_ab", {unit_out.host_interrupt_out, unit_out.host_tx_ready_n, 2'b11},
					{pad_out.tri_a.o, pad_out.tri_b.o, pad_out.tri_a.oe, pad_out.tri_b.oe});
				chk_pad("hd in", (unit_out.host_data_o & {8{unit_out.host_data_oe}}) |
					(far_lv.pa & ~{8{unit_out.host_data_oe}}), unit_in.host_data_i);
				chk_pad("gpa idle", 8'h00, unit_in.gpio_pa_i);
			end else begin
				chk_pad("pa_o", unit_out.gpio_pa_o, pad_out.pa_o);
				chk_pad("pa_oe", unit_out.gpio_pa_oe, pad_out.pa_oe);
				chk_pad("hcs idle", 1, unit_in.host_select_n);
				chk_pad("chb cd", far_lv.b_cd, unit_in.chan_b_carrier_detect_n);
				chk_pad("tx line", unit_out.chan_b_tx_line, pad_out.b_tx.o);
				chk_pad("gpa in", (unit_out.gpio_pa_o & unit_out.gpio_pa_oe) |
					(far_lv.pa & ~unit_out.gpio_pa_oe), unit_in.gpio_pa_i);
				chk_pad("hd idle", 8'h00, unit_in.host_data_i);
				chk_pad("b_tck", unit_out.chan_b_txrx_clock_n, pad_out.b_tck);
				if (sys_m[2]) begin
					chk_pad("tri_ab", {unit_out.chan_b_terminal_ready_or_request,
						unit_out.chan_b_wait_or_request, 2'b11}, {pad_out.tri_a.o,
						pad_out.tri_b.o, pad_out.tri_a.oe, pad_out.tri_b.oe});
				end else begin
					chk_pad("tri_a", unit_out.async1_clock_or_dma0_end, pad_out.tri_a);
					chk_pad("dma1_request_n", {1'b0, far_lv.tri_b}, {pad_out.tri_b.oe,
						unit_in.dma1_request_n});
				end
				chk_pad("tri_c", sys_m[2] ? unit_out.chan_b_request_to_send_n
					: unit_out.dma1_transfer_end_n, pad_out.tri_c.o);
			end
			if (sys_m[7]) begin
				chk_pad("a_cts pc1", {unit_out.pc_o[1], unit_out.pc_oe[1]},
					{pad_out.a_cts.o, pad_out.a_cts.oe});
				chk_pad("pc5 in", unit_out.pc_oe[5] ? unit_out.pc_o[5] : far_lv.a_wr,
					unit_in.pc_i[5]);
			end else begin
				chk_pad("a_cts in", far_lv.a_cts, unit_in.a_cts_n);
			end
			if (!(pin_m[3] && sys_m[7])) begin
				chk_pad("wr_pin", pin_m[3] ? unit_out.chan_a_request_to_send
					: unit_out.memory_write_strobe_n, pad_out.wr_pin.o);
			end else begin
				chk_pad("wr_pin pc2", {unit_out.pc_o[2], unit_out.pc_oe[2]},
					{pad_out.wr_pin.o, pad_out.wr_pin.oe});
				chk_pad("pc2 in", unit_out.pc_oe[2] ? unit_out.pc_o[2] : far_lv.wr_pin,
					unit_in.pc_i[2]);
			end
			if (pin_m[2]) begin
				chk_pad("chain out", {unit_out.daisy_priority_out, 1'b1},
					{pad_out.chain.o, pad_out.chain.oe});
			end else begin
				chk_pad("chain in", far_lv.chain, unit_in.daisy_priority_in);
			end
			chk_pad("rd_pin", pin_m[3] ? unit_out.memory_request_n
				: unit_out.memory_read_strobe_n, pad_out.rd_pin.o);
			chk_pad("pc76", {far_lv.irq2_n, far_lv.irq1_n}, unit_in.pc_i[7:6]);
			chk_pad("cts0", sys_m[5] ? 1'b0 : far_lv.b1_pin, unit_in.chan0_cts_n);
			apb(1'b0, 12'h008, 32'h0);
			chk_bus("portc rd", {far_lv.irq2_n, far_lv.irq1_n}, rd[7:6]);
		end
		final_report();
	end
endmodule : tb_peripheral_pin_function_mux
`default_nettype wire
